// ### core/fault_seq_pkg.sv
// constants, states and register map of the fault latch sequencer
package fault_seq_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned DEBOUNCE_MS = 25;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int unsigned BAD_FILTER_MS = 20;
   localparam int unsigned BAD_FILTER_CYCLES = BAD_FILTER_MS * (CLK_HZ / 1000);
   localparam int unsigned COOLOFF_LAPS = 512;
   localparam int unsigned CNT_W = 18;
   localparam int unsigned LAP_W = 10;

   // synchronised comparator bit positions
   localparam int unsigned CMP_W = 13;
   localparam int unsigned CMP_LOCKOUT = 0;
   localparam int unsigned CMP_UV_ON = 1;
   localparam int unsigned CMP_UV_CLEAR = 2;
   localparam int unsigned CMP_STARTUP_TRIP = 3;
   localparam int unsigned CMP_TRICKLE_OK = 4;
   localparam int unsigned CMP_MAIN_OK = 5;
   localparam int unsigned CMP_DRAIN_HIGH = 6;
   localparam int unsigned CMP_DRAIN_LOW = 7;
   localparam int unsigned CMP_BRK_HIGH = 8;
   localparam int unsigned CMP_BRK_LOW = 9;
   localparam int unsigned CMP_OVERCURRENT = 10;
   localparam int unsigned CMP_FAST_TRIP = 11;
   localparam int unsigned CMP_OUT_VALID = 12;

   // register map, byte addresses
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_COOLOFF = 4'h8;
   localparam logic [1:0] CONTROL_RESET = 2'h2;
   localparam int unsigned CTL_FORCE_OFF = 0;
   localparam int unsigned CTL_BOOST_ALLOW = 1;

   typedef enum logic [2:0] {
      SEQ_OFF = 3'h0,
      SEQ_DEBOUNCE = 3'h1,
      SEQ_STARTUP = 3'h2,
      SEQ_RUN = 3'h3,
      SEQ_COOLOFF = 3'h4,
      SEQ_LATCHED = 3'h5,
      SEQ_BAD_SWITCH = 3'h6
   } seq_state_t;

   typedef enum logic [1:0] {
      KIND_NONE = 2'h0,
      KIND_STARTUP = 2'h1,
      KIND_COOLOFF = 2'h2,
      KIND_BAD_SWITCH = 2'h3
   } fault_kind_t;
endpackage

// ### core/comparator_sync.sv
// two-stage synchroniser for the comparator result vector
`timescale 1ns/1ps
module comparator_sync #(
   parameter int unsigned WIDTH = 13
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] synced
);
   typedef struct packed {
      logic [WIDTH-1:0] meta_ff;
      logic [WIDTH-1:0] sync_ff;
   } sync_state_t;

   sync_state_t st_ff;
   sync_state_t nxt_st;

   // first stage feeds only the second stage
   always_comb begin
      nxt_st.meta_ff = raw;
      nxt_st.sync_ff = st_ff.meta_ff;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign synced = st_ff.sync_ff;
endmodule // comparator_sync

// ### core/fault_latch_sequencer.sv
// start-up, switch health and fault latch sequencer with avalon register port
`timescale 1ns/1ps
// Notes on behaviour
// - gates weak at start timer: fault, both pulled down
// - start-up fault skips the cool-off sequence
// - drain to kelvin over 100mV flags bad switch
// - main gate below 10V flags bad switch
// - 20ms filter runs, zeroes when both absent
// - filter expiry: flag low, main gate pulled
// - bad switch clears only at supply lockout
// - drain low at debounce end: shorted switch
// - shorted switch runs 512-lap cool-off first
// - start-up and cool-off faults latch off; enable below 0.6V clears
// - enable low in cool-off clears at end
// - cleared and enable high: debounce then start-up
// - bad switch after power good holds flag low
// - supply lockout clears everything, even cool-off
// - boost doubles main channel thresholds
// - boost never touches start-up channel limit
// - monitor grounded while output below 3.7V
// - fast trip turns switches off within 1us
// - cool-off cycles breaker pin, flag stays low
// - every overcurrent fault goes through cool-off
module fault_latch_sequencer #(
   parameter int unsigned DEBOUNCE_LEN = fault_seq_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned BAD_FILTER_LEN = fault_seq_pkg::BAD_FILTER_CYCLES,
   parameter int unsigned COOLOFF_LEN = fault_seq_pkg::COOLOFF_LAPS
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic supply_lockout_in,
   input wire logic undervoltage_enable_in,
   input wire logic undervoltage_clear_in,
   input wire logic startup_timer_pin,
   input wire logic trickle_gate_enhanced,
   input wire logic main_gate_enhanced,
   input wire logic drain_kelvin_high,
   input wire logic drain_kelvin_low,
   input wire logic breaker_timer_high,
   input wire logic breaker_timer_low,
   input wire logic overcurrent_in,
   input wire logic fast_trip_in,
   input wire logic output_above_min,
   input wire logic threshold_boost_in,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic fault_flag_n,
   output logic power_good_out,
   output logic trickle_gate_drive,
   output logic main_gate_drive,
   output logic trickle_gate_pulldown,
   output logic main_gate_pulldown,
   output logic breaker_timer_charge,
   output logic breaker_timer_discharge,
   output logic main_threshold_double,
   output logic current_monitor_clamp
);
   typedef struct packed {
      fault_seq_pkg::seq_state_t state;
      fault_seq_pkg::fault_kind_t kind;
      logic [fault_seq_pkg::CNT_W-1:0] count;
      logic [fault_seq_pkg::CNT_W-1:0] bad_count;
      logic [fault_seq_pkg::LAP_W-1:0] laps;
      logic cool_charge;
      logic [1:0] control;
      logic waitreq;
      logic [31:0] rdata;
      logic flag_n;
      logic pg;
      logic trickle_on;
      logic main_on;
      logic trickle_pd;
      logic main_pd;
      logic brk_chg;
      logic brk_dis;
      logic boost;
      logic mon_clamp;
   } seq_t;

   seq_t st_ff;
   seq_t nxt_st;
   logic [fault_seq_pkg::CMP_W-1:0] cmp;
   logic [fault_seq_pkg::CMP_W-1:0] cmp_raw;

   // counts reached, compared at counter width
   function automatic logic reached(input logic [fault_seq_pkg::CNT_W-1:0] cnt,
                                    input int unsigned len);
      reached = (cnt >= fault_seq_pkg::CNT_W'(len - 1));
   endfunction

   assign cmp_raw = {output_above_min, fast_trip_in, overcurrent_in, breaker_timer_low,
                     breaker_timer_high, drain_kelvin_low, drain_kelvin_high,
                     main_gate_enhanced, trickle_gate_enhanced, startup_timer_pin,
                     undervoltage_clear_in, undervoltage_enable_in, supply_lockout_in};

   comparator_sync #(
      .WIDTH(fault_seq_pkg::CMP_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .raw(cmp_raw),
      .synced(cmp)
   );

   always_comb begin
      logic lockout;
      logic uv_on;
      logic uv_clear;
      logic bad_cond;
      logic overcur;
      logic enable_ok;
      logic req;
      lockout = cmp[fault_seq_pkg::CMP_LOCKOUT];
      uv_on = cmp[fault_seq_pkg::CMP_UV_ON];
      uv_clear = cmp[fault_seq_pkg::CMP_UV_CLEAR];
      // boost widens the bad-switch window too, done in the analog comparator
      bad_cond = cmp[fault_seq_pkg::CMP_DRAIN_HIGH]
                 | ~cmp[fault_seq_pkg::CMP_MAIN_OK];
      overcur = cmp[fault_seq_pkg::CMP_OVERCURRENT];
      enable_ok = uv_on & ~uv_clear & ~st_ff.control[fault_seq_pkg::CTL_FORCE_OFF];
      req = avs_read | avs_write;
      nxt_st = st_ff;

      // bus slave: one wait cycle, then answer for one cycle
      nxt_st.waitreq = ~(req & st_ff.waitreq);
      if (req & st_ff.waitreq) begin
         nxt_st.rdata = '0;
         unique case (avs_address)
            fault_seq_pkg::REG_CONTROL: nxt_st.rdata[1:0] = st_ff.control;
            fault_seq_pkg::REG_STATUS: nxt_st.rdata[9:0] = {st_ff.pg, ~st_ff.flag_n,
               st_ff.main_on, st_ff.trickle_on, st_ff.kind, 1'b0, st_ff.state};
            fault_seq_pkg::REG_COOLOFF: nxt_st.rdata[fault_seq_pkg::LAP_W-1:0] = st_ff.laps;
            default: nxt_st.rdata = '0;
         endcase
      end
      if (avs_write & ~st_ff.waitreq & (avs_address == fault_seq_pkg::REG_CONTROL)) begin
         nxt_st.control = avs_writedata[1:0];
      end

      unique case (st_ff.state)
         fault_seq_pkg::SEQ_OFF: begin
            nxt_st.count = '0;
            if (enable_ok) begin
               nxt_st.state = fault_seq_pkg::SEQ_DEBOUNCE;
            end
         end
         fault_seq_pkg::SEQ_DEBOUNCE: begin
            nxt_st.count = st_ff.count + 1'b1;
            if (!enable_ok) begin
               nxt_st.state = fault_seq_pkg::SEQ_OFF;
            end else if (reached(st_ff.count, DEBOUNCE_LEN)) begin
               nxt_st.count = '0;
               if (cmp[fault_seq_pkg::CMP_DRAIN_LOW]) begin
                  nxt_st.state = fault_seq_pkg::SEQ_COOLOFF;
                  nxt_st.kind = fault_seq_pkg::KIND_COOLOFF;
                  nxt_st.cool_charge = 1'b0;
                  nxt_st.laps = '0;
               end else begin
                  nxt_st.state = fault_seq_pkg::SEQ_STARTUP;
               end
            end
         end
         fault_seq_pkg::SEQ_STARTUP: begin
            if (overcur) begin
               nxt_st.state = fault_seq_pkg::SEQ_COOLOFF;
               nxt_st.kind = fault_seq_pkg::KIND_COOLOFF;
               nxt_st.cool_charge = 1'b0;
               nxt_st.laps = '0;
            end else if (cmp[fault_seq_pkg::CMP_STARTUP_TRIP]) begin
               if (cmp[fault_seq_pkg::CMP_TRICKLE_OK] & cmp[fault_seq_pkg::CMP_MAIN_OK]) begin
                  nxt_st.state = fault_seq_pkg::SEQ_RUN;
                  nxt_st.bad_count = '0;
               end else begin
                  // straight to the latch, no cool-off laps
                  nxt_st.state = fault_seq_pkg::SEQ_LATCHED;
                  nxt_st.kind = fault_seq_pkg::KIND_STARTUP;
               end
            end else if (!enable_ok) begin
               nxt_st.state = fault_seq_pkg::SEQ_OFF;
            end
         end
         fault_seq_pkg::SEQ_RUN: begin
            if (bad_cond) begin
               nxt_st.bad_count = st_ff.bad_count + 1'b1;
            end else begin
               nxt_st.bad_count = '0;
            end
            if (overcur | ~cmp[fault_seq_pkg::CMP_OUT_VALID]) begin
               nxt_st.state = fault_seq_pkg::SEQ_COOLOFF;
               nxt_st.kind = fault_seq_pkg::KIND_COOLOFF;
               nxt_st.cool_charge = 1'b0;
               nxt_st.laps = '0;
            end else if (bad_cond & reached(st_ff.bad_count, BAD_FILTER_LEN)) begin
               nxt_st.state = fault_seq_pkg::SEQ_BAD_SWITCH;
               nxt_st.kind = fault_seq_pkg::KIND_BAD_SWITCH;
            end else if (!enable_ok) begin
               nxt_st.state = fault_seq_pkg::SEQ_OFF;
            end
         end
         fault_seq_pkg::SEQ_COOLOFF: begin
            // first lap starts with a discharge down to the low trip
            if (st_ff.cool_charge & cmp[fault_seq_pkg::CMP_BRK_HIGH]) begin
               nxt_st.cool_charge = 1'b0;
            end else if (!st_ff.cool_charge & cmp[fault_seq_pkg::CMP_BRK_LOW]) begin
               if (st_ff.laps == fault_seq_pkg::LAP_W'(COOLOFF_LEN)) begin
                  // enable held low through cool-off clears here
                  nxt_st.state = uv_clear ? fault_seq_pkg::SEQ_OFF
                                          : fault_seq_pkg::SEQ_LATCHED;
                  nxt_st.kind = uv_clear ? fault_seq_pkg::KIND_NONE : st_ff.kind;
               end else begin
                  nxt_st.cool_charge = 1'b1;
                  nxt_st.laps = st_ff.laps + 1'b1;
               end
            end
         end
         fault_seq_pkg::SEQ_LATCHED: begin
            if (uv_clear) begin
               nxt_st.state = fault_seq_pkg::SEQ_OFF;
               nxt_st.kind = fault_seq_pkg::KIND_NONE;
            end
         end
         fault_seq_pkg::SEQ_BAD_SWITCH: begin
            // enable pin is ignored; only lockout leaves this state
            nxt_st.state = fault_seq_pkg::SEQ_BAD_SWITCH;
         end
         default: begin
            nxt_st.state = fault_seq_pkg::SEQ_OFF;
         end
      endcase

      // supply lockout wipes the latch, kind and timers in any state
      if (lockout) begin
         nxt_st.state = fault_seq_pkg::SEQ_OFF;
         nxt_st.kind = fault_seq_pkg::KIND_NONE;
         nxt_st.count = '0;
         nxt_st.bad_count = '0;
         nxt_st.laps = '0;
         nxt_st.cool_charge = 1'b0;
      end

      // registered pin drive; flag, gates and breaker pins from the next state
      nxt_st.pg = (nxt_st.state == fault_seq_pkg::SEQ_RUN);
      nxt_st.flag_n = ~(nxt_st.state == fault_seq_pkg::SEQ_COOLOFF
                        || nxt_st.state == fault_seq_pkg::SEQ_LATCHED
                        || nxt_st.state == fault_seq_pkg::SEQ_BAD_SWITCH);
      nxt_st.trickle_on = (nxt_st.state == fault_seq_pkg::SEQ_STARTUP
                           || nxt_st.state == fault_seq_pkg::SEQ_RUN)
                          & ~cmp[fault_seq_pkg::CMP_FAST_TRIP];
      nxt_st.main_on = ((nxt_st.state == fault_seq_pkg::SEQ_STARTUP
                         & cmp[fault_seq_pkg::CMP_TRICKLE_OK])
                        || nxt_st.state == fault_seq_pkg::SEQ_RUN)
                       & ~cmp[fault_seq_pkg::CMP_FAST_TRIP];
      nxt_st.trickle_pd = ~nxt_st.trickle_on;
      nxt_st.main_pd = ~nxt_st.main_on;
      nxt_st.brk_chg = (nxt_st.state == fault_seq_pkg::SEQ_COOLOFF) & nxt_st.cool_charge;
      nxt_st.brk_dis = (nxt_st.state == fault_seq_pkg::SEQ_COOLOFF) & ~nxt_st.cool_charge;
      // start-up channel has no boost output at all
      nxt_st.boost = threshold_boost_in
                     & st_ff.control[fault_seq_pkg::CTL_BOOST_ALLOW];
      nxt_st.mon_clamp = ~cmp[fault_seq_pkg::CMP_OUT_VALID];
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.waitreq <= 1'b1;
         st_ff.flag_n <= 1'b1;
         st_ff.trickle_pd <= 1'b1;
         st_ff.main_pd <= 1'b1;
         st_ff.mon_clamp <= 1'b1;
         st_ff.control <= fault_seq_pkg::CONTROL_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.waitreq;
   assign fault_flag_n = st_ff.flag_n;
   assign power_good_out = st_ff.pg;
   assign trickle_gate_drive = st_ff.trickle_on;
   assign main_gate_drive = st_ff.main_on;
   assign trickle_gate_pulldown = st_ff.trickle_pd;
   assign main_gate_pulldown = st_ff.main_pd;
   assign breaker_timer_charge = st_ff.brk_chg;
   assign breaker_timer_discharge = st_ff.brk_dis;
   assign main_threshold_double = st_ff.boost;
   assign current_monitor_clamp = st_ff.mon_clamp;
endmodule // fault_latch_sequencer

// ### sim/fault_seq_monitor.sv
// port checker for the fault latch sequencer
`timescale 1ns/1ps
module fault_seq_monitor #(
   parameter int unsigned DEBOUNCE_LEN = 20,
   parameter int unsigned BAD_FILTER_LEN = 10,
   parameter int unsigned COOLOFF_LEN = 3
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic supply_lockout_in,
   input wire logic fast_trip_in,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic fault_flag_n,
   input wire logic power_good_out,
   input wire logic trickle_gate_drive,
   input wire logic main_gate_drive,
   input wire logic trickle_gate_pulldown,
   input wire logic main_gate_pulldown,
   input wire logic breaker_timer_charge,
   input wire logic breaker_timer_discharge
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low too long");
   trickle_pull_a: assert property (trickle_gate_pulldown != trickle_gate_drive)
      else $error("trickle pulldown and drive disagree");
   main_pull_a: assert property (main_gate_pulldown != main_gate_drive)
      else $error("main pulldown and drive disagree");
   fault_gates_a: assert property (!fault_flag_n |-> !power_good_out && !main_gate_drive)
      else $error("gate on while fault flagged");
   fast_trip_a: assert property ($rose(fast_trip_in) |-> ##[1:3] !main_gate_drive)
      else $error("fast trip too slow");
   // lockout sampled four times to cover sync and output flops
   lockout_off_a: assert property (supply_lockout_in [*4] |=>
      !trickle_gate_drive && !main_gate_drive && fault_flag_n) else $error("lockout ignored");
   cool_flag_a: assert property (breaker_timer_charge || breaker_timer_discharge
      |-> !fault_flag_n) else $error("breaker cycling without fault flag");
   cover property ($fell(fault_flag_n));
   cover property ($rose(power_good_out));
   cover property ($rose(breaker_timer_charge));
endmodule // fault_seq_monitor

bind fault_latch_sequencer fault_seq_monitor #(.DEBOUNCE_LEN(DEBOUNCE_LEN),
   .BAD_FILTER_LEN(BAD_FILTER_LEN), .COOLOFF_LEN(COOLOFF_LEN)) i_fault_seq_monitor (.*);

// ### sim/switch_plant_model.sv
// behavioural pass switches, load output and breaker timer capacitor
`timescale 1ns/1ps
module switch_plant_model (
   input wire logic sys_clk,
   input wire logic weak_gate,
   input wire logic drain_short,
   input wire logic drain_drop,
   input wire logic trickle_gate_drive,
   input wire logic main_gate_drive,
   input wire logic breaker_timer_charge,
   input wire logic breaker_timer_discharge,
   output logic trickle_gate_enhanced = 1'b0,
   output logic main_gate_enhanced = 1'b0,
   output logic drain_kelvin_high = 1'b0,
   output logic drain_kelvin_low = 1'b0,
   output logic breaker_timer_high = 1'b0,
   output logic breaker_timer_low = 1'b0,
   output logic output_above_min = 1'b0
);
   // capacitor in coarse steps, so one lap spans several cycles
   logic [2:0] level_ff = 3'h2;
   always @(posedge sys_clk) begin
      trickle_gate_enhanced <= trickle_gate_drive & ~weak_gate;
      main_gate_enhanced <= main_gate_drive & ~weak_gate;
      drain_kelvin_high <= drain_drop & main_gate_drive;
      // a conducting or shorted switch leaves little drain voltage
      drain_kelvin_low <= drain_short | trickle_gate_drive | main_gate_drive;
      output_above_min <= trickle_gate_drive | main_gate_drive;
      if (breaker_timer_charge && level_ff != 3'h4) begin
         level_ff <= level_ff + 3'h1;
      end else if (breaker_timer_discharge && level_ff != 3'h0) begin
         level_ff <= level_ff - 3'h1;
      end
      breaker_timer_high <= (level_ff == 3'h4);
      breaker_timer_low <= (level_ff == 3'h0);
   end
endmodule // switch_plant_model

// ### sim/test_fault_latch_sequencer.sv
// self-checking bench for the fault latch sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_fault_latch_sequencer;
   logic sys_clk = 1'b0, srst = 1'b1, supply_lockout_in = 1'b0, fast_trip_in = 1'b0;
   logic undervoltage_enable_in = 1'b0, undervoltage_clear_in = 1'b0, overcurrent_in = 1'b0;
   logic startup_timer_pin = 1'b1, threshold_boost_in = 1'b0, weak_gate = 1'b1;
   logic drain_short = 1'b0, drain_drop = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic trickle_gate_enhanced, main_gate_enhanced, drain_kelvin_high, drain_kelvin_low;
   logic breaker_timer_high, breaker_timer_low, output_above_min, avs_waitrequest;
   logic fault_flag_n, power_good_out, trickle_gate_drive, main_gate_drive;
   logic trickle_gate_pulldown, main_gate_pulldown, breaker_timer_charge;
   logic breaker_timer_discharge, main_threshold_double, current_monitor_clamp;
   int n_errors = 0;
   int cmp_count = 0;
   fault_latch_sequencer #(.DEBOUNCE_LEN(20), .BAD_FILTER_LEN(10), .COOLOFF_LEN(3))
      i_fault_latch_sequencer (.*);
   switch_plant_model i_switch_plant_model (.*);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int i;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      `CHK(i < 20, 1'b1)
      if (i == 20) tally_and_finish();
   endtask
   // status polled over the bus; outputs get two cycles to follow
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int k;
      for (k = 0; k < 400; k++) begin
         bus(1'b0, fault_seq_pkg::REG_STATUS, 32'h0);
         if ((rd & m) === v) break;
      end
      `CHK(rd & m, v)
      if (k == 400) tally_and_finish();
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic start_up;
      startup_timer_pin <= 1'b0;
      poll(32'h80, 32'h80);
      bus(1'b0, fault_seq_pkg::REG_STATUS, 32'h0);
      startup_timer_pin <= 1'b1;
      poll(32'h7, fault_seq_pkg::SEQ_RUN);
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      `CHK(current_monitor_clamp, 1'b1)
      bus(1'b0, fault_seq_pkg::REG_CONTROL, 32'h0);
      `CHK(rd, 32'h2)
      bus(1'b1, fault_seq_pkg::REG_STATUS, 32'h3f);
      bus(1'b0, fault_seq_pkg::REG_STATUS, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b0, 4'hc, 32'h0);
      `CHK(rd, 32'h0)
      // weak gates with the start timer already tripped
      undervoltage_enable_in <= 1'b1;
      poll(32'h3f, {26'h0, fault_seq_pkg::KIND_STARTUP, 1'b0, fault_seq_pkg::SEQ_LATCHED});
      `CHK({fault_flag_n, trickle_gate_pulldown, main_gate_pulldown}, 3'b011)
      bus(1'b0, fault_seq_pkg::REG_COOLOFF, 32'h0);
      `CHK({rd, breaker_timer_charge, breaker_timer_discharge}, 34'h0)
      undervoltage_clear_in <= 1'b1;
      poll(32'h7, fault_seq_pkg::SEQ_OFF);
      `CHK(fault_flag_n, 1'b1)
      undervoltage_clear_in <= 1'b0;
      weak_gate <= 1'b0;
      start_up();
      `CHK({power_good_out, current_monitor_clamp}, 2'b10)
      threshold_boost_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK(main_threshold_double, 1'b1)
      bus(1'b1, fault_seq_pkg::REG_CONTROL, 32'h0);
      repeat (4) @(posedge sys_clk);
      `CHK(main_threshold_double, 1'b0)
      bus(1'b1, fault_seq_pkg::REG_CONTROL, 32'h2);
      for (int j = 0; j < 2; j++) begin
         drain_drop <= 1'b1;
         repeat (6) @(posedge sys_clk);
         drain_drop <= 1'b0;
         repeat (12) @(posedge sys_clk);
      end
      bus(1'b0, fault_seq_pkg::REG_STATUS, 32'h0);
      `CHK(rd[2:0], fault_seq_pkg::SEQ_RUN)
      // neither source alone lasts the filter; back to back they do
      drain_drop <= 1'b1;
      repeat (6) @(posedge sys_clk);
      drain_drop <= 1'b0;
      weak_gate <= 1'b1;
      repeat (7) @(posedge sys_clk);
      weak_gate <= 1'b0;
      poll(32'h3f, {26'h0, fault_seq_pkg::KIND_BAD_SWITCH, 1'b0, fault_seq_pkg::SEQ_BAD_SWITCH});
      `CHK({fault_flag_n, main_gate_pulldown, power_good_out}, 3'b010)
      undervoltage_clear_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      bus(1'b0, fault_seq_pkg::REG_STATUS, 32'h0);
      `CHK(rd[2:0], fault_seq_pkg::SEQ_BAD_SWITCH)
      `CHK(fault_flag_n, 1'b0)
      supply_lockout_in <= 1'b1;
      startup_timer_pin <= 1'b0;
      drain_short <= 1'b1;
      poll(32'h7, fault_seq_pkg::SEQ_OFF);
      `CHK(fault_flag_n, 1'b1)
      supply_lockout_in <= 1'b0;
      undervoltage_clear_in <= 1'b0;
      poll(32'h3f, {26'h0, fault_seq_pkg::KIND_COOLOFF, 1'b0, fault_seq_pkg::SEQ_COOLOFF});
      `CHK(fault_flag_n, 1'b0)
      `CHK(breaker_timer_charge | breaker_timer_discharge, 1'b1)
      undervoltage_clear_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      bus(1'b0, fault_seq_pkg::REG_STATUS, 32'h0);
      `CHK(rd[2:0], fault_seq_pkg::SEQ_COOLOFF)
      poll(32'h7, fault_seq_pkg::SEQ_OFF);
      undervoltage_clear_in <= 1'b0;
      drain_short <= 1'b0;
      start_up();
      fast_trip_in <= 1'b1;
      overcurrent_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK({trickle_gate_drive, main_gate_drive}, 2'b00)
      fast_trip_in <= 1'b0;
      overcurrent_in <= 1'b0;
      poll(32'h7, fault_seq_pkg::SEQ_COOLOFF);
      poll(32'h7, fault_seq_pkg::SEQ_LATCHED);
      `CHK(fault_flag_n, 1'b0)
      undervoltage_clear_in <= 1'b1;
      poll(32'h7, fault_seq_pkg::SEQ_OFF);
      tally_and_finish();
   end
endmodule // test_fault_latch_sequencer
